// >>> inc/cts_map.svh
/*
  Constants of the cycle time supervisor: setup word offsets, reset
  values, field positions and timing counts.
  Assumes a 250 MHz core clock; all times are in the unit named.
*/
`ifndef CTS_MAP_SVH
`define CTS_MAP_SVH

// Setup word offsets
`define CTS_MIN_ADDR 8'hd0
`define CTS_WATCH_ADDR 8'hd1

// Setup word reset values
`define CTS_MIN_RESET 16'h0000
`define CTS_WATCH_RESET 16'h0001

// Watch limit setup fields
`define CTS_WATCH_EN_BIT 15
`define CTS_WATCH_VAL_MSB 14

// Legal setting ranges
`define CTS_MIN_MAX 16'h7d00
`define CTS_WATCH_MAX 15'h0fa0

// Clock and measurement step, in ns
`define CTS_CLK_NS 4
`define CTS_TICK_NS 100000
`define CTS_MS_NS 1000000
`define CTS_TICK_CYCLES (`CTS_TICK_NS / `CTS_CLK_NS)

// Setting units and limits, in ms
`define CTS_MIN_UNIT_MS 1
`define CTS_WATCH_UNIT_MS 10
`define CTS_WATCH_DEFAULT_MS 1000
`define CTS_PERIPH_LIMIT_MS 2000

// The same, as counts of 0.1 ms steps
`define CTS_MIN_UNIT_TICKS (`CTS_MIN_UNIT_MS * `CTS_MS_NS / `CTS_TICK_NS)
`define CTS_WATCH_UNIT_TICKS (`CTS_WATCH_UNIT_MS * `CTS_MS_NS / `CTS_TICK_NS)
`define CTS_WATCH_DEFAULT_TICKS (`CTS_WATCH_DEFAULT_MS * `CTS_MS_NS / `CTS_TICK_NS)
`define CTS_PERIPH_LIMIT_TICKS (`CTS_PERIPH_LIMIT_MS * `CTS_MS_NS / `CTS_TICK_NS)

// History of cycle times for the average
`define CTS_HIST_SHIFT 3

`endif

// >>> inc/cts_pkg.sv
/*
  Types of the cycle time supervisor: state codes and the state
  records of each module.
  Assumes nothing of its surroundings.
*/
package cts_pkg;

  // Supervisor sequence
  typedef enum logic [1:0] {
    CTS_IDLE = 2'h0,
    CTS_EXEC = 2'h1,
    CTS_PAD = 2'h2,
    CTS_HALT = 2'h3
  } cts_state_type;

  // Top level state
  typedef struct packed {
    cts_state_type st;
    logic [15:0] min_set;
    logic [15:0] watch_set;
    logic [15:0] rdata;
    logic [31:0] present;
    logic [31:0] maxv;
    logic [31:0] periph_word;
    logic cyc_flag;
    logic per_flag;
    logic cyc_start;
  } cts_top_state_type;

  // Elapsed time counter state
  typedef struct packed {
    logic [15:0] sub;
    logic [31:0] elapsed;
  } cts_timer_state_type;

  // Cycle time history state
  typedef struct packed {
    logic [7:0][31:0] mem;
    logic [2:0] ptr;
    logic [34:0] sum;
    logic [31:0] avg;
  } cts_hist_state_type;

endpackage : cts_pkg

// >>> verilog/cts_timer.sv
/*
  Elapsed time counter in 0.1 ms steps, restartable, saturating.
  Assumes the core clock and a synchronous active low reset.
*/
`include "cts_map.svh"

module cts_timer #(
  parameter int TICK_CYCLES = `CTS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic restart_i,
  // Result
  output logic [31:0] elapsed_o
);

  cts_pkg::cts_timer_state_type s; // Present state
  cts_pkg::cts_timer_state_type next_s; // Next state

  // Step counter; the elapsed count sticks at all ones instead of wrapping
  always_comb begin
    next_s = s;
    if (restart_i) begin
      next_s.sub = 16'h0;
      next_s.elapsed = 32'h0;
    end else if (s.sub == 16'(TICK_CYCLES - 1)) begin
      next_s.sub = 16'h0;
      if (s.elapsed != 32'hffffffff) begin
        next_s.elapsed = s.elapsed + 32'h1;
      end
    end else begin
      next_s.sub = s.sub + 16'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign elapsed_o = s.elapsed;

endmodule : cts_timer

// >>> verilog/cts_hist.sv
/*
  Eight-entry history of cycle times with a registered running average.
  Assumes writes come at most once per clock from the supervisor.
*/
`include "cts_map.svh"

module cts_hist (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [31:0] data_i,
  // Result
  output logic [31:0] avg_o
);

  cts_pkg::cts_hist_state_type s; // Present state
  cts_pkg::cts_hist_state_type next_s; // Next state

  // Running sum avoids an eight-way adder: add the new, drop the oldest
  always_comb begin
    next_s = s;
    if (clear_i) begin
      next_s = '0;
    end else if (wr_i) begin
      next_s.mem[s.ptr] = data_i;
      next_s.ptr = s.ptr + 3'h1;
      next_s.sum = s.sum - {3'h0, s.mem[s.ptr]} + {3'h0, data_i};
    end
    next_s.avg = next_s.sum[34:`CTS_HIST_SHIFT];
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign avg_o = s.avg;

endmodule : cts_hist

// >>> verilog/cts_top.sv
/*
  Cycle time supervisor: pads short cycles to a minimum, halts on a too
  long cycle or peripheral servicing cycle, records cycle times.
  Assumes the controller's execution and servicing strobes come from
  logic on the same clock, and the setup words are written over the
  setup port.
*/
`include "cts_map.svh"

module cts_top #(
  parameter int TICK_CYCLES = `CTS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Setup words
  input wire logic SETUP_WE_I,
  input wire logic [7:0] SETUP_ADDR_I,
  input wire logic [15:0] SETUP_WDATA_I,
  output logic [15:0] SETUP_RDATA_O,
  // Controller sequence
  input wire logic START_I,
  input wire logic PARALLEL_MODE_I,
  input wire logic EXEC_DONE_I,
  input wire logic PERIPH_END_I,
  output logic CYCLE_START_O,
  output logic RUN_O,
  // Status words
  output logic [31:0] PRESENT_CYCLE_TIME_O,
  output logic [31:0] MAX_CYCLE_TIME_O,
  output logic [31:0] AVG_CYCLE_TIME_O,
  output logic [31:0] PERIPHERAL_SERVICE_TIME_WORD_O,
  output logic CYCLE_OVERRUN_FLAG_O,
  output logic PERIPHERAL_OVERRUN_FLAG_O
);

  cts_pkg::cts_top_state_type s; // Present state
  cts_pkg::cts_top_state_type next_s; // Next state
  logic [31:0] cyc_elapsed; // Time since cycle start
  logic [31:0] per_elapsed; // Time since servicing cycle start
  logic [31:0] min_ticks; // Minimum period in 0.1 ms steps
  logic [31:0] limit_ticks; // Watch limit in 0.1 ms steps
  logic running; // Program cycles in progress
  logic cyc_over; // Cycle beyond the watch limit
  logic per_over; // Servicing beyond its limit
  logic record; // Cycle ends this clock
  logic per_restart; // Servicing timer restarts
  logic begin_run; // Operation begins

  // Setting decode; one millisecond is ten steps
  always_comb begin
    min_ticks = 32'(s.min_set) * 32'(`CTS_MIN_UNIT_TICKS);
    if (s.watch_set[`CTS_WATCH_EN_BIT] && s.watch_set[`CTS_WATCH_VAL_MSB:0] != 15'h0 &&
        s.watch_set[`CTS_WATCH_VAL_MSB:0] <= `CTS_WATCH_MAX) begin
      // Explicit limit in 10 ms units
      limit_ticks = 32'(s.watch_set[`CTS_WATCH_VAL_MSB:0]) *
                    32'(`CTS_WATCH_UNIT_TICKS);
    end else begin
      // Default one second, also for an illegal code
      limit_ticks = 32'(`CTS_WATCH_DEFAULT_TICKS);
    end
  end

  // Derived conditions
  assign running = (s.st == cts_pkg::CTS_EXEC) || (s.st == cts_pkg::CTS_PAD);
  assign cyc_over = (s.st == cts_pkg::CTS_EXEC) && (cyc_elapsed > limit_ticks);
  // Servicing is a cycle of its own only in parallel mode
  assign per_over = running && PARALLEL_MODE_I &&
                    (per_elapsed > 32'(`CTS_PERIPH_LIMIT_TICKS));
  // Start is only taken while stopped; a start while cycling is ignored
  assign begin_run = START_I && ((s.st == cts_pkg::CTS_IDLE) || (s.st == cts_pkg::CTS_HALT));
  assign per_restart = begin_run || (running && PERIPH_END_I);

  // Sequence, setup and status update
  always_comb begin
    next_s = s;
    next_s.cyc_start = 1'b0;
    record = 1'b0;
    // Setup writes; out of range minimum codes are ignored
    if (SETUP_WE_I && SETUP_ADDR_I == `CTS_MIN_ADDR &&
        SETUP_WDATA_I <= `CTS_MIN_MAX) begin
      next_s.min_set = SETUP_WDATA_I;
    end
    if (SETUP_WE_I && SETUP_ADDR_I == `CTS_WATCH_ADDR) begin
      next_s.watch_set = SETUP_WDATA_I;
    end
    // Readback of the setup words
    if (SETUP_ADDR_I == `CTS_MIN_ADDR) begin
      next_s.rdata = s.min_set;
    end else if (SETUP_ADDR_I == `CTS_WATCH_ADDR) begin
      next_s.rdata = s.watch_set;
    end else begin
      next_s.rdata = 16'h0;
    end
    unique case (s.st)
      cts_pkg::CTS_IDLE, cts_pkg::CTS_HALT: begin
        // Start clears the error flags and the maximum
        if (START_I) begin
          next_s.st = cts_pkg::CTS_EXEC;
          next_s.cyc_start = 1'b1;
          next_s.maxv = 32'h0;
          next_s.present = 32'h0;
          next_s.cyc_flag = 1'b0;
          next_s.per_flag = 1'b0;
        end
      end
      cts_pkg::CTS_EXEC: begin
        // An overrun in the same clock as the finish still counts
        if (cyc_over) begin
          next_s.st = cts_pkg::CTS_HALT;
          next_s.cyc_flag = 1'b1;
        end else if (EXEC_DONE_I && cyc_elapsed < min_ticks) begin
          next_s.st = cts_pkg::CTS_PAD;
        end else if (EXEC_DONE_I) begin
          record = 1'b1;
        end
      end
      cts_pkg::CTS_PAD: begin
        // Padding ends when the minimum has elapsed
        if (cyc_elapsed >= min_ticks) begin
          next_s.st = cts_pkg::CTS_EXEC;
          record = 1'b1;
        end
      end
    endcase
    // Cycle end: store times and start the next cycle
    // A servicing timeout below still halts, the words keep this cycle's time
    if (record) begin
      next_s.cyc_start = 1'b1;
      next_s.present = cyc_elapsed;
      if (cyc_elapsed > s.maxv) begin
        next_s.maxv = cyc_elapsed;
      end
    end
    // Servicing timeout stops everything, taking priority
    if (per_over) begin
      next_s.st = cts_pkg::CTS_HALT;
      next_s.per_flag = 1'b1;
      next_s.cyc_start = 1'b0;
    end else if (running && PARALLEL_MODE_I && PERIPH_END_I) begin
      next_s.periph_word = per_elapsed;
    end
  end

  // State register
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      s <= '0;
      s.st <= cts_pkg::CTS_IDLE;
      s.min_set <= `CTS_MIN_RESET;
      s.watch_set <= `CTS_WATCH_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Cycle timer restarts with each cycle start, so padding is counted
  // A servicing timeout suppresses the restart, so the halted time stays visible
  cts_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_cyc_timer (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .restart_i(next_s.cyc_start),
    .elapsed_o(cyc_elapsed)
  );

  // Servicing timer restarts at each servicing cycle end
  cts_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_per_timer (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .restart_i(per_restart),
    .elapsed_o(per_elapsed)
  );

  // Last eight cycle times for the average
  cts_hist u_hist (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .clear_i(begin_run),
    .wr_i(record && !per_over),
    .data_i(cyc_elapsed),
    .avg_o(AVG_CYCLE_TIME_O)
  );

  // Outputs, all from the state register
  assign SETUP_RDATA_O = s.rdata;
  assign CYCLE_START_O = s.cyc_start;
  assign RUN_O = running;
  assign PRESENT_CYCLE_TIME_O = s.present;
  assign MAX_CYCLE_TIME_O = s.maxv;
  assign PERIPHERAL_SERVICE_TIME_WORD_O = s.periph_word;
  assign CYCLE_OVERRUN_FLAG_O = s.cyc_flag;
  assign PERIPHERAL_OVERRUN_FLAG_O = s.per_flag;

  // Checks
  // All checks run on the core clock and sleep while reset is applied
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  chk_min_range: assert property (s.min_set <= `CTS_MIN_MAX)
    else $error("minimum setting out of range");

  chk_pad_hold: assert property (
    (s.st == cts_pkg::CTS_PAD && cyc_elapsed < min_ticks && !per_over)
      |=> !CYCLE_START_O && s.st == cts_pkg::CTS_PAD)
    else $error("cycle restarted before minimum");

  chk_pad_release: assert property (
    (s.st == cts_pkg::CTS_PAD && cyc_elapsed >= min_ticks && !per_over)
      |=> CYCLE_START_O && PRESENT_CYCLE_TIME_O == $past(cyc_elapsed))
    else $error("padding did not end at minimum");

  chk_no_pad: assert property (
    (s.st == cts_pkg::CTS_EXEC && EXEC_DONE_I && !cyc_over && !per_over &&
     cyc_elapsed >= min_ticks) |=> CYCLE_START_O && s.st == cts_pkg::CTS_EXEC)
    else $error("long cycle was padded");

  chk_overrun_halt: assert property (
    (s.st == cts_pkg::CTS_EXEC && cyc_elapsed > limit_ticks)
      |=> (CYCLE_OVERRUN_FLAG_O && !RUN_O)
      ##1 ($past(START_I) || (CYCLE_OVERRUN_FLAG_O && !RUN_O)))
    else $error("overrun did not halt");

  chk_limit_default: assert property (
    !s.watch_set[`CTS_WATCH_EN_BIT] |-> limit_ticks == 32'h2710)
    else $error("default watch limit wrong");

  chk_limit_scaled: assert property (
    (s.watch_set[`CTS_WATCH_EN_BIT] && s.watch_set[14:0] == 15'h0fa0)
      |-> limit_ticks == 32'h61a80)
    else $error("scaled watch limit wrong");

  chk_periph_halt: assert property (
    (running && PARALLEL_MODE_I && per_elapsed > 32'h4e20)
      |=> PERIPHERAL_OVERRUN_FLAG_O && s.st == cts_pkg::CTS_HALT)
    else $error("servicing timeout did not halt");

  chk_periph_word: assert property (
    (running && !PARALLEL_MODE_I) |=> $stable(PERIPHERAL_SERVICE_TIME_WORD_O))
    else $error("servicing word changed outside parallel mode");

  chk_max_track: assert property (
    CYCLE_START_O |-> MAX_CYCLE_TIME_O >= PRESENT_CYCLE_TIME_O)
    else $error("maximum below present");

  chk_max_start: assert property (
    (begin_run && !per_over) |=> MAX_CYCLE_TIME_O == 32'h0 ##1 RUN_O)
    else $error("maximum not cleared at start");

  chk_cycle_record: assert property (
    (record && !per_over) |=> CYCLE_START_O &&
      PRESENT_CYCLE_TIME_O == $past(cyc_elapsed) && MAX_CYCLE_TIME_O >= PRESENT_CYCLE_TIME_O)
    else $error("cycle end did not update the times");

  chk_min_top: assert property (
    s.min_set == 16'h7d00 |-> min_ticks == 32'h0004e200)
    else $error("top minimum setting decoded wrong");

  chk_limit_fallback: assert property (
    (s.watch_set[`CTS_WATCH_EN_BIT] && s.watch_set[14:0] == 15'h0)
      |-> limit_ticks == 32'h2710)
    else $error("zero watch code did not fall back");

  chk_start_clear: assert property (
    begin_run |=> CYCLE_START_O && RUN_O && !CYCLE_OVERRUN_FLAG_O && !PERIPHERAL_OVERRUN_FLAG_O)
    else $error("start did not clear the flags");

  chk_halt_hold: assert property (
    (s.st == cts_pkg::CTS_HALT && !START_I) |=> !RUN_O && !CYCLE_START_O)
    else $error("halted supervisor resumed without start");

  chk_periph_store: assert property (
    (running && PARALLEL_MODE_I && PERIPH_END_I && !per_over)
      |=> PERIPHERAL_SERVICE_TIME_WORD_O == $past(per_elapsed))
    else $error("servicing time not stored");

  chk_avg_clear: assert property (
    begin_run |=> AVG_CYCLE_TIME_O == 32'h0)
    else $error("history not cleared at start");

  // Main scenarios
  cov_padding: cover property (s.st == cts_pkg::CTS_PAD ##1 CYCLE_START_O);
  cov_overrun: cover property ($rose(CYCLE_OVERRUN_FLAG_O));
  cov_periph: cover property ($rose(PERIPHERAL_OVERRUN_FLAG_O));
  cov_long_cycle: cover property (s.st == cts_pkg::CTS_EXEC && EXEC_DONE_I &&
    min_ticks != 32'h0 && cyc_elapsed > min_ticks);
  cov_service_word: cover property (running && PARALLEL_MODE_I && PERIPH_END_I);

endmodule : cts_top

// >>> bench/tb.sv
/*
  Self-checking bench of the cycle time supervisor: setup words, padding,
  long cycles, recorded times, average, watch limit and servicing timeout.
  Assumes the design header and package are compiled first, and that a
  shortened step of four clocks per 0.1 ms is accepted by the design.
*/
`include "cts_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Shortened step keeps the servicing timeout run near 80,000 clocks
  localparam int TICK = 4;
  localparam int MT = 3 * `CTS_MIN_UNIT_TICKS;  // 3 ms minimum, in steps
  localparam int WT = `CTS_WATCH_UNIT_TICKS;    // One watch unit, in steps
  localparam int PT = `CTS_PERIPH_LIMIT_TICKS;  // Servicing limit, in steps

  // Stimulus
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic we = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic start = 1'b0;
  logic par = 1'b0;
  logic done = 1'b0;
  logic pend = 1'b0;
  // Observed
  logic [15:0] rdata;
  logic cstart, run, cflag, pflag;
  logic [31:0] pres, maxv, avg, pword;
  // Bookkeeping
  int err_count = 0;
  int comparisons = 0;
  int n;
  int i;
  logic [31:0] m;

  // Core clock, 4 ns period
  always #2 clk = ~clk;

  cts_top #(.TICK_CYCLES(TICK)) u_cts_top (
    .CLK_I(clk), .RSTN_I(rstn), .SETUP_WE_I(we), .SETUP_ADDR_I(addr),
    .SETUP_WDATA_I(wdata), .SETUP_RDATA_O(rdata), .START_I(start),
    .PARALLEL_MODE_I(par), .EXEC_DONE_I(done), .PERIPH_END_I(pend),
    .CYCLE_START_O(cstart), .RUN_O(run), .PRESENT_CYCLE_TIME_O(pres),
    .MAX_CYCLE_TIME_O(maxv), .AVG_CYCLE_TIME_O(avg),
    .PERIPHERAL_SERVICE_TIME_WORD_O(pword), .CYCLE_OVERRUN_FLAG_O(cflag),
    .PERIPHERAL_OVERRUN_FLAG_O(pflag)
  );

  // Verdict, reached from the main sequence and from any exhausted wait
  task summarize();
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // One comparison; four-state so an unknown never matches
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Window test; an unknown value yields a mismatch
  function automatic logic [31:0] inr(input logic [31:0] v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction : inr

  // Setup word write, one-cycle strobe
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
  endtask : wr

  // Readback is registered, so it settles one edge after the address
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    check("setup readback", {16'h0, rdata}, {16'h0, exp});
  endtask : rd

  // One-cycle pulse: 0 start, 1 execution done, 2 servicing end
  task pulse(input int w);
    @(negedge clk);
    case (w)
      0: start = 1'b1;
      1: done = 1'b1;
      default: pend = 1'b1;
    endcase
    @(negedge clk);
    start = 1'b0;
    done = 1'b0;
    pend = 1'b0;
  endtask : pulse

  // Execute for hold clocks, then wait for the next cycle start
  task cyc(input int hold, output int cnt);
    cnt = 0;
    repeat (hold) begin
      @(negedge clk);
      cnt++;
    end
    pulse(1);
    cnt += 2;
    while (cstart !== 1'b1 && cnt < 3000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 3000) begin
      $display("Error cycle start wait expected 1 seen 0");
      err_count++;
      summarize();
    end
  endtask : cyc

  // Count clocks until the supervisor stops, bounded
  task wait_halt(input int bound, output int cnt);
    cnt = 0;
    while (run === 1'b1 && cnt < bound) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= bound) begin
      $display("Error halt wait expected 0 seen 1");
      err_count++;
      summarize();
    end
  endtask : wait_halt

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    // Reset values of the setup words and status
    rd(`CTS_MIN_ADDR, 16'h0000);
    rd(`CTS_WATCH_ADDR, 16'h0001);
    check("run", {31'h0, run}, 32'h0);
    // Out of range minimum refused, top of range kept, then 3 ms
    wr(`CTS_MIN_ADDR, 16'h7d01);
    rd(`CTS_MIN_ADDR, 16'h0000);
    wr(`CTS_MIN_ADDR, 16'h7d00);
    rd(`CTS_MIN_ADDR, 16'h7d00);
    wr(`CTS_MIN_ADDR, 16'h0003);
    pulse(0);
    check("cycle start", {31'h0, cstart}, 32'h1);
    // Servicing end outside parallel mode leaves the word alone
    pulse(2);
    check("service word", pword, 32'h0);
    cyc(0, n);
    check("present padded", pres, MT);
    // Long execution: no padding, maximum follows
    cyc(200, n);
    check("long period", inr(n, 200, 206), 32'h1);
    check("long present", inr(pres, 49, 52), 32'h1);
    check("max follows", maxv, pres);
    m = maxv;
    // Eight padded cycles fill the history with the same time
    for (i = 0; i < 8; i++) begin
      cyc(0, n);
      check("padded period", inr(n, MT * TICK - 2, MT * TICK + 2), 32'h1);
    end
    check("max kept", maxv, m);
    check("present", pres, MT);
    repeat (2) @(negedge clk);
    check("average", avg, MT);
    // Zero minimum means no padding; 10 ms watch limit
    wr(`CTS_MIN_ADDR, 16'h0000);
    wr(`CTS_WATCH_ADDR, 16'h8000);
    wr(`CTS_WATCH_ADDR, 16'h8001);
    rd(`CTS_WATCH_ADDR, 16'h8001);
    cyc(0, n);
    check("unpadded period", inr(n, 2, 4), 32'h1);
    // Execution never ends: overrun just past one watch unit
    wait_halt(1000, n);
    check("overrun time", inr(n, (WT + 1) * TICK - 8, (WT + 1) * TICK + 8), 32'h1);
    check("cycle flag", {31'h0, cflag}, 32'h1);
    check("servicing flag", {31'h0, pflag}, 32'h0);
    // Parallel mode: wide watch limit, servicing word, then timeout
    wr(`CTS_WATCH_ADDR, 16'h8fa0);
    par = 1'b1;
    pulse(0);
    check("flag cleared", {31'h0, cflag}, 32'h0);
    repeat (100) @(negedge clk);
    check("max from zero", maxv, 32'h0);
    pulse(2);
    check("service word", inr(pword, 20, 30), 32'h1);
    wait_halt(90000, n);
    check("servicing timeout", inr(n, PT * TICK - 12, PT * TICK + 12), 32'h1);
    check("servicing flag", {31'h0, pflag}, 32'h1);
    check("cycle flag", {31'h0, cflag}, 32'h0);
    summarize();
  end

endmodule : tb
